// ===== sdrcp_ctrl.sv
// sdram command pin interface: controller end
// closed-page policy, one word per request, auto precharge on every access
`timescale 1ns/1ps
module sdrcp_ctrl (
  sdrcp_if.ctrl       pins,
  input  wire logic   mclk,
  input  wire logic   resetn,
  input  wire logic   req_valid,
  output logic        req_ready,
  input  wire logic   req_write,
  input  wire logic [1:0]  req_bank,
  input  wire logic [11:0] req_row,
  input  wire logic [7:0]  req_col,
  input  wire logic [15:0] req_data,
  input  wire logic [1:0]  req_mask,
  output logic        rd_valid,
  output logic [15:0] rd_data,
  input  wire logic   pd_req,
  input  wire logic   sr_req,
  output logic        ctrl_ready
);
  typedef enum logic [9:0] {
    S_INIT = 10'h001, S_PREA = 10'h002, S_REF = 10'h004, S_LMR = 10'h008, S_IDLE = 10'h010,
    S_ACT  = 10'h020, S_RW   = 10'h040, S_WAIT = 10'h080, S_PD  = 10'h100, S_SR   = 10'h200
  } sdrcp_cst_type;
  typedef struct packed {
    sdrcp_cst_type           st;
    sdrcp_cst_type           nxt;
    logic [15:0]             cnt;
    logic [15:0]             refi;
    logic                    ref_due;
    logic                    inited;
    logic [1:0]              nref;
    logic                    cke;
    logic [3:0]              cmd;
    logic [1:0]              ba;
    logic [11:0]             addr;
    logic [15:0]             dq;
    logic [1:0]              oe;
    logic [1:0]              dm;
    sdrcp_pkg::sdrcp_req_type cur;
    logic [3:0]              rd_sh;
    logic                    rd_v;
    logic [15:0]             rd_d;
  } sdrcp_ctrl_type;
  sdrcp_ctrl_type q, d;
  sdrcp_pkg::sdrcp_req_type f_data;
  logic f_valid;
  logic take;

  sdrcp_fifo #(
    .WIDTH ($bits(sdrcp_pkg::sdrcp_req_type)),
    .DEPTH (sdrcp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_write, req_bank, req_row, req_col, req_data, req_mask}),
    .out_valid (f_valid),
    .out_ready (take),
    .out_data  (f_data)
  );

  always_comb begin
    d       = q;
    take    = 1'b0;
    d.cmd   = sdrcp_pkg::CMD_NOP;
    d.oe    = 2'h0;
    d.dm    = 2'h0;
    d.rd_v  = 1'b0;
    d.rd_sh = {q.rd_sh[2:0], 1'b0};
    // read word sits on the pins cas latency plus one edge after issue
    if (q.rd_sh[sdrcp_pkg::RD_CL]) begin
      d.rd_v = 1'b1;
      d.rd_d = pins.data_bus;
    end
    case (q.st)
      S_INIT: begin
        d.cke = (q.cnt <= 16'(sdrcp_pkg::INIT_CYC / 2));
        d.cnt = q.cnt - 16'h0001;
        if (q.cnt == 16'h0000) begin
          d.st = S_PREA;
        end
      end
      S_PREA: begin
        d.cmd      = sdrcp_pkg::CMD_PRE;
        d.addr     = 12'h400;
        d.nref     = 2'h2;
        d.st       = S_WAIT;
        d.nxt      = S_REF;
        d.cnt      = 16'(sdrcp_pkg::RP_CYC - 1);
      end
      S_REF: begin
        d.cmd     = sdrcp_pkg::CMD_REF;
        d.ref_due = 1'b0;
        d.nref    = q.nref - 2'h1;
        d.st      = S_WAIT;
        d.nxt     = (q.nref > 2'h1) ? S_REF : (q.inited ? S_IDLE : S_LMR);
        d.cnt     = 16'(sdrcp_pkg::RFC_CYC - 1);
      end
      S_LMR: begin
        d.cmd    = sdrcp_pkg::CMD_LMR;
        d.ba     = 2'h0;
        d.addr   = sdrcp_pkg::MODE_WORD;
        d.inited = 1'b1;
        d.st     = S_WAIT;
        d.nxt    = S_IDLE;
        d.cnt    = 16'(sdrcp_pkg::T_MRD_CK - 1);
      end
      S_IDLE: begin
        if (sr_req) begin
          d.cmd = sdrcp_pkg::CMD_REF;
          d.cke = 1'b0;
          d.st  = S_SR;
        end else if (q.ref_due) begin
          d.nref = 2'h1;
          d.st   = S_REF;
        end else if (f_valid) begin
          take  = 1'b1;
          d.cur = f_data;
          d.st  = S_ACT;
        end else if (pd_req) begin
          d.cke = 1'b0;
          d.st  = S_PD;
        end
      end
      S_ACT: begin
        d.cmd  = sdrcp_pkg::CMD_ACT;
        d.ba   = q.cur.bank;
        d.addr = q.cur.row;
        d.st   = S_WAIT;
        d.nxt  = S_RW;
        d.cnt  = 16'(sdrcp_pkg::RCD_CYC - 1);
      end
      S_RW: begin
        d.addr = {4'h4, q.cur.col};
        if (q.cur.wr) begin
          d.cmd = sdrcp_pkg::CMD_WR;
          d.dq  = q.cur.data;
          d.oe  = 2'h3;
          d.dm  = q.cur.mask;
        end else begin
          d.cmd      = sdrcp_pkg::CMD_RD;
          d.rd_sh[0] = 1'b1;
        end
        d.st  = S_WAIT;
        d.nxt = S_IDLE;
        d.cnt = 16'(sdrcp_pkg::POST_CYC - 1);
      end
      S_WAIT: begin
        d.cnt = q.cnt - 16'h0001;
        if (q.cnt == 16'h0000) begin
          d.st = q.nxt;
        end
      end
      S_PD: begin
        if (!pd_req || q.ref_due) begin
          d.cke = 1'b1;
          d.st  = S_IDLE;
        end
      end
      S_SR: begin
        if (!sr_req) begin
          d.cke = 1'b1;
          d.st  = S_WAIT;
          d.nxt = S_IDLE;
          d.cnt = 16'(sdrcp_pkg::RFC_CYC - 1);
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
    // refresh tick sets after any clear above so a coincident tick survives
    if (q.refi == 16'h0000) begin
      d.refi    = 16'(sdrcp_pkg::REFI_CYC - 1);
      d.ref_due = q.inited;
    end else begin
      d.refi = q.refi - 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q      <= '0;
      q.st   <= S_INIT;
      q.nxt  <= S_IDLE;
      q.cnt  <= sdrcp_pkg::RST_CNT;
      q.cmd  <= sdrcp_pkg::CMD_NOP;
    end else begin
      q <= d;
    end
  end

  assign pins.cke             = q.cke;
  assign pins.cs_n            = q.cmd[3];
  assign pins.ras_n           = q.cmd[2];
  assign pins.cas_n           = q.cmd[1];
  assign pins.we_n            = q.cmd[0];
  assign pins.bank_select_0   = q.ba[0];
  assign pins.bank_select_1   = q.ba[1];
  assign pins.address_bus     = q.addr;
  assign pins.lower_byte_mask = q.dm[0];
  assign pins.upper_byte_mask = q.dm[1];
  assign pins.ctrl_dq_out     = q.dq;
  assign pins.ctrl_dq_oe      = q.oe;
  assign rd_valid             = q.rd_v;
  assign rd_data              = q.rd_d;
  assign ctrl_ready           = (q.st == S_IDLE) && q.inited;
endmodule : sdrcp_ctrl

// ===== sdrcp_pkg.sv
// sdram command pin interface: shared constants, command codes, request layout
// assumes a 10 MHz mclk and the sixteen-bit organization throughout
package sdrcp_pkg;
  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int DATA_W         = 16;
  localparam int ADDR_W         = 12;
  localparam int COL_W          = 8;
  localparam int NBANK          = 4;
  localparam int ADDRESS_BIT_10 = 10;
  localparam int MR_BL_LSB      = 0;
  localparam int MR_BT_BIT      = 3;
  localparam int MR_CL_LSB      = 4;
  localparam int MR_WB_BIT      = 9;
  localparam int MEM_AW         = 10;
  localparam int FIFO_DEPTH     = 32;
  localparam logic [2:0]  BL_FULL   = 3'h7;
  localparam logic [11:0] MODE_WORD = 12'h020;
  localparam int RD_CL = int'(MODE_WORD[MR_CL_LSB +: 3]);
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ   = 10;
  localparam int T_INIT_US = 100;
  localparam int T_RP_NS   = 20;
  localparam int T_RCD_NS  = 20;
  localparam int T_RFC_NS  = 70;
  localparam int T_REFI_NS = 15625;
  localparam int T_MRD_CK  = 2;
  localparam int T_WR_CK   = 2;
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up
  function automatic int cyc_dn(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : cyc_dn
  localparam int INIT_CYC = T_INIT_US * CLK_MHZ;
  localparam int RP_CYC   = cyc_up(T_RP_NS);
  localparam int RCD_CYC  = cyc_up(T_RCD_NS);
  localparam int RFC_CYC  = cyc_up(T_RFC_NS);
  localparam int REFI_CYC = cyc_dn(T_REFI_NS);
  localparam int POST_CYC = RD_CL + T_WR_CK + RP_CYC;
  localparam logic [15:0] RST_CNT = 16'(INIT_CYC);
  // ----------------------------------------------------------------
  // command codes {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_LMR = 4'h0, CMD_REF = 4'h1, CMD_PRE = 4'h2, CMD_ACT = 4'h3,
    CMD_WR  = 4'h4, CMD_RD  = 4'h5, CMD_BST = 4'h6, CMD_NOP = 4'h7,
    CMD_INH = 4'hf
  } sdrcp_cmd_type;
  typedef struct packed {
    logic              wr;
    logic [1:0]        bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0]  col;
    logic [DATA_W-1:0] data;
    logic [1:0]        mask;
  } sdrcp_req_type;
endpackage : sdrcp_pkg

// ===== sdrcp_if.sv
// sdram command pin interface: the pins between controller and memory
// data_bus is resolved here from the two drivers' byte enables
`timescale 1ns/1ps
interface sdrcp_if;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic        bank_select_0;
  logic        bank_select_1;
  logic        lower_byte_mask;
  logic        upper_byte_mask;
  logic [11:0] address_bus;
  logic [15:0] ctrl_dq_out;
  logic [1:0]  ctrl_dq_oe;
  logic [15:0] dev_dq_out;
  logic [1:0]  dev_dq_oe;
  logic [15:0] data_bus;
  // undriven lanes read as zero rather than floating
  assign data_bus[7:0]  = dev_dq_oe[0] ? dev_dq_out[7:0] : ctrl_dq_oe[0] ? ctrl_dq_out[7:0] : 8'h00;
  assign data_bus[15:8] = dev_dq_oe[1] ? dev_dq_out[15:8] : ctrl_dq_oe[1] ? ctrl_dq_out[15:8] : 8'h00;
  modport device (input cke, cs_n, ras_n, cas_n, we_n, bank_select_0, bank_select_1,
                  lower_byte_mask, upper_byte_mask, address_bus, data_bus,
                  output dev_dq_out, dev_dq_oe);
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank_select_0, bank_select_1,
                lower_byte_mask, upper_byte_mask, address_bus, ctrl_dq_out, ctrl_dq_oe,
                input data_bus);
endinterface : sdrcp_if

// ===== sdrcp_fifo.sv
// request fifo: parameterised width and depth, valid/ready on both sides
// assumes depth is a power of two
`timescale 1ns/1ps
module sdrcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sdrcp_fifo_type;
  sdrcp_fifo_type q, d;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic             push;
  logic             pop;

  assign in_ready  = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
  assign out_valid = (q.wp != q.rp);
  assign out_data  = mem[q.rp[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[q.wp[AW-1:0]] <= in_data;
    end
  end
endmodule : sdrcp_fifo

// ===== sdrcp_device.sv
// sdram command pin interface: memory end (x16, four banks)
// assumes the controller drives the pins from mclk; a small array stands
// in for the cell matrix, so rows and columns alias above its index width
`timescale 1ns/1ps
module sdrcp_device (
  sdrcp_if.device   pins,
  input  wire logic mclk,
  input  wire logic resetn,
  output logic [4:0]  power_state,
  output logic [3:0]  bank_open,
  output logic [11:0] mode_word
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    PW_RUN  = 5'h01,
    PW_SUSP = 5'h02,
    PW_PPD  = 5'h04,
    PW_APD  = 5'h08,
    PW_SREF = 5'h10
  } sdrcp_pwr_type;
  typedef struct packed {
    sdrcp_pwr_type     pwr;
    logic [11:0]       mode;
    logic [3:0]        row_open;
    logic [3:0][11:0]  row;
    logic              burst_on;
    logic              burst_wr;
    logic              burst_ap;
    logic [1:0]        burst_bank;
    logic [7:0]        burst_col;
    logic [8:0]        burst_cnt;
    logic [2:0]        rd_v;
    logic [2:0][15:0]  rd_data;
    logic [1:0][1:0]   dqm_p;
    logic [15:0]       dq_q;
    logic [1:0]        oe_q;
  } sdrcp_dev_type;
  sdrcp_dev_type q, d;
  logic [15:0] mem [0:(1 << sdrcp_pkg::MEM_AW)-1];
  logic [sdrcp_pkg::MEM_AW-1:0] mem_a;
  logic [1:0]  mem_we;
  logic [3:0]  cmd;
  logic [1:0]  bank;
  logic [1:0]  mask;
  logic [7:0]  col;
  logic [8:0]  blen;
  logic        lowp;
  logic        adv;
  int          idx;

  // ----------------------------------------------------------------
  // burst helpers
  // ----------------------------------------------------------------
  function automatic logic [8:0] burst_len(input logic [11:0] mr);
    logic [2:0] bl;
    bl = mr[sdrcp_pkg::MR_BL_LSB +: 3];
    if (mr[sdrcp_pkg::MR_WB_BIT]) begin
      return 9'h001;
    end
    if (bl == sdrcp_pkg::BL_FULL) begin
      return 9'h100;
    end
    return (bl > 3'h3) ? 9'h001 : (9'h001 << bl);
  endfunction : burst_len

  // wraps inside the block of burst_len columns; interleave is an xor
  function automatic logic [7:0] burst_col(input logic [7:0] s, input logic [8:0] c,
                                            input logic [8:0] len, input logic bt);
    logic [7:0] m;
    m = 8'(len - 9'h001);
    return (s & ~m) | ((bt ? (s ^ c[7:0]) : (s + c[7:0])) & m);
  endfunction : burst_col

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d      = q;
    mem_we = 2'h0;
    mem_a  = '0;
    col    = 8'h00;
    idx    = (q.mode[sdrcp_pkg::MR_CL_LSB +: 3] == 3'h3) ? 1 : 0;
    blen   = burst_len(q.mode);
    bank   = {pins.bank_select_1, pins.bank_select_0};
    lowp   = (q.pwr == PW_PPD) || (q.pwr == PW_APD) || (q.pwr == PW_SREF);
    cmd    = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
    mask   = {pins.upper_byte_mask, pins.lower_byte_mask};
    if (lowp) begin
      cmd  = sdrcp_pkg::CMD_NOP;
      mask = 2'h0;
    end
    if (cmd[3]) begin
      cmd = sdrcp_pkg::CMD_NOP;
    end
    adv = (q.pwr == PW_RUN) && pins.cke;
    case (q.pwr)
      PW_RUN: begin
        if (!pins.cke) begin
          if (q.burst_on) begin
            d.pwr = PW_SUSP;
          end else if (cmd == sdrcp_pkg::CMD_REF) begin
            d.pwr = PW_SREF;
          end else if (|q.row_open) begin
            d.pwr = PW_APD;
          end else begin
            d.pwr = PW_PPD;
          end
        end
      end
      PW_SUSP: begin
        if (pins.cke) begin
          d.pwr = PW_RUN;
        end
      end
      PW_PPD, PW_APD, PW_SREF: begin
        // no command or edge qualification: the enable alone wakes us
        if (pins.cke) begin
          d.pwr = PW_RUN;
        end
      end
      default: begin
        d.pwr = PW_RUN;
      end
    endcase
    if (adv) begin
      d.dqm_p[1]   = q.dqm_p[0];
      d.dqm_p[0]   = mask;
      d.rd_v       = {q.rd_v[1:0], 1'b0};
      d.rd_data[2] = q.rd_data[1];
      d.rd_data[1] = q.rd_data[0];
      d.dq_q       = q.rd_data[idx];
      d.oe_q       = {2{q.rd_v[idx]}} & ~q.dqm_p[1];
      if (q.burst_on) begin
        d.burst_cnt = q.burst_cnt + 9'h001;
      end
      case (cmd)
        sdrcp_pkg::CMD_ACT: begin
          d.row_open[bank] = 1'b1;
          d.row[bank]      = pins.address_bus;
        end
        sdrcp_pkg::CMD_RD, sdrcp_pkg::CMD_WR: begin
          d.burst_on   = 1'b1;
          d.burst_wr   = (cmd == sdrcp_pkg::CMD_WR);
          d.burst_ap   = pins.address_bus[sdrcp_pkg::ADDRESS_BIT_10];
          d.burst_bank = bank;
          d.burst_col  = pins.address_bus[sdrcp_pkg::COL_W-1:0];
          d.burst_cnt  = 9'h000;
        end
        sdrcp_pkg::CMD_BST: begin
          d.burst_on = 1'b0;
        end
        sdrcp_pkg::CMD_PRE: begin
          if (pins.address_bus[sdrcp_pkg::ADDRESS_BIT_10]) begin
            d.row_open = 4'h0;
          end else begin
            d.row_open[bank] = 1'b0;
          end
        end
        sdrcp_pkg::CMD_LMR: begin
          d.mode = pins.address_bus;
        end
        default: begin
        end
      endcase
      if (d.burst_on) begin
        col   = burst_col(d.burst_col, d.burst_cnt, blen, q.mode[sdrcp_pkg::MR_BT_BIT]);
        mem_a = {d.burst_bank, d.row[d.burst_bank][1:0], col[5:0]};
        if (d.burst_wr) begin
          mem_we = ~mask;
        end else begin
          d.rd_v[0]    = 1'b1;
          d.rd_data[0] = mem[mem_a];
        end
        if (d.burst_cnt + 9'h001 >= blen) begin
          d.burst_on = 1'b0;
          if (d.burst_ap) begin
            d.row_open[d.burst_bank] = 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers and array
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q     <= '0;
      q.pwr <= PW_RUN;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge mclk) begin
    if (mem_we[0]) begin
      mem[mem_a][7:0] <= pins.data_bus[7:0];
    end
    if (mem_we[1]) begin
      mem[mem_a][15:8] <= pins.data_bus[15:8];
    end
  end

  // the full sixteen lanes are always present in this organization
  assign pins.dev_dq_out = q.dq_q;
  assign pins.dev_dq_oe  = q.oe_q;
  assign power_state     = q.pwr;
  assign bank_open       = q.row_open;
  assign mode_word       = q.mode;
endmodule : sdrcp_device

// ===== sdrcp_properties.sv
// checker for the pin link between the controller and memory ends
// assumes it sits beside the interface in the test top, on mclk
`timescale 1ns/1ps
module sdrcp_properties (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic        bank_select_0,
  input wire logic        bank_select_1,
  input wire logic        lower_byte_mask,
  input wire logic        upper_byte_mask,
  input wire logic [11:0] address_bus,
  input wire logic [1:0]  ctrl_dq_oe,
  input wire logic [1:0]  dev_dq_oe
);
  logic [3:0] cmd;
  logic [1:0] bank, act_bank_q, act_bank_d;
  logic       is_act, is_rd, is_wr;
  assign cmd    = {cs_n, ras_n, cas_n, we_n};
  assign bank   = {bank_select_1, bank_select_0};
  assign is_act = cke && cmd == sdrcp_pkg::CMD_ACT;
  assign is_rd  = cke && cmd == sdrcp_pkg::CMD_RD;
  assign is_wr  = cke && cmd == sdrcp_pkg::CMD_WR;
  // remembers the bank opened last, so column commands can be tied to it
  always_comb begin
    act_bank_d = is_act ? bank : act_bank_q;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) act_bank_q <= 2'h0;
    else act_bank_q <= act_bank_d;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_WR_OE: assert property (is_wr |-> ctrl_dq_oe == 2'h3)
    else $error("write without data drive");
  AST_RW_AUTO_PRE: assert property ((is_rd || is_wr) |-> address_bus[sdrcp_pkg::ADDRESS_BIT_10])
    else $error("column access without auto precharge");
  AST_RW_BANK: assert property ((is_rd || is_wr) |-> bank == act_bank_q)
    else $error("column access to a bank not opened");
  AST_ACT_TO_RW: assert property (is_act |-> ##[1:4] (is_rd || is_wr))
    else $error("open row not followed by access");
  AST_RD_DRIVE: assert property (is_rd && !lower_byte_mask && !upper_byte_mask |-> ##2 dev_dq_oe == 2'h3)
    else $error("read word not driven two edges later");
  AST_OE_CAUSE: assert property ($rose(dev_dq_oe[0]) |-> $past(is_rd, 2))
    else $error("memory drives without a read");
  AST_NO_CLASH: assert property ((ctrl_dq_oe & dev_dq_oe) == 2'h0)
    else $error("both ends drive the data bus");
  AST_PRE_ALL: assert property (cke && cmd == sdrcp_pkg::CMD_PRE |-> address_bus[sdrcp_pkg::ADDRESS_BIT_10])
    else $error("precharge not for all banks");
  AST_LMR_OP: assert property (cke && cmd == sdrcp_pkg::CMD_LMR |-> address_bus == sdrcp_pkg::MODE_WORD && bank == 2'h0)
    else $error("mode load with wrong opcode");
  AST_LOW_QUIET: assert property (!cke && !$past(cke) |-> cs_n || cmd == sdrcp_pkg::CMD_NOP)
    else $error("command while clock enable low");
  COV_WRITE_MASKED: cover property (is_wr && lower_byte_mask);
  COV_READ: cover property (is_rd);
  COV_CKE_FALL: cover property ($fell(cke));
endmodule : sdrcp_properties

// ===== sdram_command_pin_interface_test.sv
// self-checking bench: controller and memory ends joined by the pin interface
// assumes a 100 ns mclk; user side driven at falling edges
`timescale 1ns/1ps
module sdram_command_pin_interface_test;
  logic        mclk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic        pd_req = 1'b0, sr_req = 1'b0, req_ready, rd_valid, ctrl_ready;
  logic [1:0]  req_bank = 2'h0, req_mask = 2'h0;
  logic [11:0] req_row = 12'h000, mode_word;
  logic [7:0]  req_col = 8'h00;
  logic [15:0] req_data = 16'h0000, rd_data;
  logic [4:0]  power_state;
  logic [3:0]  bank_open;
  int          error_cnt = 0, num_checks = 0, refused = 0;
  sdrcp_if u_sdrcp_if ();
  sdrcp_ctrl u_sdrcp_ctrl (.pins(u_sdrcp_if), .mclk, .resetn, .req_valid, .req_ready, .req_write, .req_bank,
    .req_row, .req_col, .req_data, .req_mask, .rd_valid, .rd_data, .pd_req, .sr_req, .ctrl_ready);
  sdrcp_device u_sdrcp_device (.pins(u_sdrcp_if), .mclk, .resetn, .power_state, .bank_open, .mode_word);
  sdrcp_properties u_sdrcp_properties (.mclk, .resetn, .cke(u_sdrcp_if.cke), .cs_n(u_sdrcp_if.cs_n),
    .ras_n(u_sdrcp_if.ras_n), .cas_n(u_sdrcp_if.cas_n), .we_n(u_sdrcp_if.we_n),
    .bank_select_0(u_sdrcp_if.bank_select_0), .bank_select_1(u_sdrcp_if.bank_select_1),
    .lower_byte_mask(u_sdrcp_if.lower_byte_mask), .upper_byte_mask(u_sdrcp_if.upper_byte_mask),
    .address_bus(u_sdrcp_if.address_bus), .ctrl_dq_oe(u_sdrcp_if.ctrl_dq_oe), .dev_dq_oe(u_sdrcp_if.dev_dq_oe));
  always #50 mclk = ~mclk;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // valid stays up between calls so pushes can run one per cycle
  task automatic push(input logic w, input logic [1:0] b, input logic [11:0] r, input logic [7:0] c,
                      input logic [15:0] d, input logic [1:0] m);
    int n;
    n = 0;
    @(negedge mclk);
    {req_write, req_bank, req_row, req_col, req_data, req_mask} = {w, b, r, c, d, m};
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 2000) begin
      refused++;
      n++;
      @(negedge mclk);
    end
    check("request taken", 16'(req_ready), 16'h0001);
  endtask : push
  task automatic idle();
    @(negedge mclk);
    req_valid = 1'b0;
  endtask : idle
  task automatic get(output logic [15:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    while (rd_valid !== 1'b1 && n < 1000) begin
      n++;
      @(negedge mclk);
    end
    check("read valid", 16'(rd_valid), 16'h0001);
    d = rd_data;
  endtask : get
  task automatic wait_ready();
    int n;
    n = 0;
    repeat (4) @(negedge mclk);
    while (ctrl_ready !== 1'b1 && n < 3000) begin
      n++;
      @(negedge mclk);
    end
    check("controller ready", 16'(ctrl_ready), 16'h0001);
  endtask : wait_ready
  task automatic wait_state(input logic [4:0] s);
    int n;
    n = 0;
    while (power_state !== s && n < 300) begin
      n++;
      @(negedge mclk);
    end
    check("power state", 16'(power_state), 16'(s));
  endtask : wait_state
  task automatic t_mask();
    logic [15:0] d;
    push(1'b1, 2'h1, 12'h005, 8'h03, 16'h1234, 2'h0);
    push(1'b1, 2'h1, 12'h005, 8'h03, 16'habcd, 2'h1);
    push(1'b1, 2'h1, 12'h005, 8'h03, 16'h5566, 2'h2);
    push(1'b1, 2'h1, 12'h005, 8'h03, 16'hffff, 2'h3);
    push(1'b0, 2'h1, 12'h005, 8'h03, 16'h0000, 2'h0);
    idle();
    get(d);
    check("masked word", d, 16'hab66);
  endtask : t_mask
  task automatic t_banks();
    logic [15:0] d;
    for (int b = 0; b < 4; b++) push(1'b1, 2'(b), 12'(12'hffc + b), 8'(8'hf0 + b), {4'(b), 12'h3c5}, 2'h0);
    for (int b = 0; b < 4; b++) push(1'b0, 2'(b), 12'(12'hffc + b), 8'(8'hf0 + b), 16'h0000, 2'h0);
    idle();
    for (int b = 0; b < 4; b++) begin
      get(d);
      check("bank word", d, {4'(b), 12'h3c5});
    end
  endtask : t_banks
  task automatic t_fill();
    logic [15:0] d;
    refused = 0;
    for (int i = 0; i < 40; i++) push(1'b1, 2'h2, 12'h000, 8'(i), 16'(16'h7000 + i), 2'h0);
    push(1'b0, 2'h2, 12'h000, 8'h27, 16'h0000, 2'h0);
    push(1'b0, 2'h2, 12'h000, 8'h00, 16'h0000, 2'h0);
    idle();
    check("fifo refused", 16'(refused > 0), 16'h0001);
    get(d);
    check("last word", d, 16'h7027);
    get(d);
    check("first word", d, 16'h7000);
    wait_ready();
    check("rows open", 16'(bank_open), 16'h0000);
  endtask : t_fill
  task automatic t_power();
    logic [15:0] d;
    pd_req = 1'b1;
    wait_state(5'h04);
    check("clock enable", 16'(u_sdrcp_if.cke), 16'h0000);
    pd_req = 1'b0;
    wait_state(5'h01);
    sr_req = 1'b1;
    wait_state(5'h10);
    sr_req = 1'b0;
    wait_state(5'h01);
    push(1'b0, 2'h1, 12'h005, 8'h03, 16'h0000, 2'h0);
    idle();
    get(d);
    check("kept word", d, 16'hab66);
  endtask : t_power
  initial begin
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    wait_ready();
    check("mode word", 16'(mode_word), 16'(sdrcp_pkg::MODE_WORD));
    t_mask();
    t_banks();
    t_fill();
    t_power();
    report_and_stop();
  end
  // init takes about a thousand cycles; the tests a few hundred more
  initial begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end
endmodule : sdram_command_pin_interface_test
